// ==== ppd_pkg.sv ====
// Shared types and constants of the pixel port front end
// Assumes the pixel clock is the one and only clock of the block
package ppd_pkg;

  // Pixel port shape
  localparam int PPD_LANES = 4;
  localparam int PPD_FIFO_DEPTH = 32;

  // Register port
  localparam int PPD_AW = 4;
  localparam int PPD_DW = 16;
  localparam logic [PPD_AW-1:0] PPD_CTRL_ADDR = 4'h0;
  localparam logic [PPD_AW-1:0] PPD_STAT_ADDR = 4'h4;
  localparam logic [PPD_DW-1:0] PPD_CTRL_RST = 16'h0102;
  localparam logic [PPD_DW-1:0] PPD_CTRL_MASK = 16'h01ff;
  localparam int PPD_S_OVF = 8;

  // Multiplex rate codes; the spare code behaves as 4:1
  localparam logic [1:0] PPD_MUX_1 = 2'h0;
  localparam logic [1:0] PPD_MUX_2 = 2'h1;
  localparam logic [1:0] PPD_MUX_4 = 2'h2;

  // Pixel format codes
  localparam logic [1:0] PPD_FMT_24 = 2'h0;
  localparam logic [1:0] PPD_FMT_15 = 2'h1;
  localparam logic [1:0] PPD_FMT_8 = 2'h2;

  // Lane index of the last pixel per mode
  localparam logic [1:0] PPD_LAST_1 = 2'h0;
  localparam logic [1:0] PPD_LAST_2 = 2'h1;
  localparam logic [1:0] PPD_LAST_4 = 2'h3;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } ppd_rgb_t;

  // One pixel lane: colour, active-low sync and blank, palette select
  typedef struct packed {
    ppd_rgb_t rgb;
    logic sync_n;
    logic blank_n;
    logic [1:0] ps;
  } ppd_lane_t;

  typedef struct packed {
    ppd_lane_t [PPD_LANES-1:0] lane;
  } ppd_word_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic run;
    logic [1:0] fmt;
    logic [1:0] match;
    logic sync_out_en;
    logic green_sync;
    logic [1:0] mux;
  } ppd_ctrl_t;

  // Digital view of the DAC drive: on means current flows at all
  typedef struct packed {
    logic on;
    logic blank;
    logic sync;
    ppd_rgb_t rgb;
  } ppd_video_t;

  typedef enum logic {
    PPD_ST_IDLE = 1'b0,
    PPD_ST_SHIFT = 1'b1
  } ppd_state_t;

endpackage

// ==== ppd_fifo.sv ====
// Word FIFO between pixel capture and the serializer
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ppd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  // Fill level
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] TOP = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;

  assign in_ready_out = level_out != FULL;
  assign out_valid_out = level_out != '0;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem[rp];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp] <= in_data_in;
    end
  end

  // Wrap by compare so that depths other than powers of two work
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= (wp == TOP) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == TOP) ? '0 : rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_out <= '0;
    end else if (push && !pop) begin
      level_out <= level_out + 1'b1;
    end else if (pop && !push) begin
      level_out <= level_out - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== ppd_pixel_port.sv ====
// Pixel port capture, lane FIFO, pixel serializer and strobe divider
// Assumes clk_in is the pixel clock; pixel pins are asynchronous to it
// Functional notes
// R1: Accept 96 colour inputs as four 24-bit pixel lanes.
// R2: Capture all colour data on every rising load strobe edge.
// R3: Frame buffer drives load strobe at pixel rate divided by mux rate.
// R4: Sync, blank and palette select are latched with colour, same lanes.
// R5: Pipeline on pixel clock; strobe frequency-locked, any phase accepted.
// R6: Blank forces blanking level, sync forces sync level.
// R7: Sync goes onto green only when green sync bit is set.
// R8: Separate digital sync output, enabled by bit, same latency as video.
// R9: Selected only when both palette select bits match programmed bits.
// R10: Unselected pixel forces all three colour outputs off.
// R11: Palette selection evaluated per pixel, serialized like colour lanes.
// R12: In 1:1 mode the load strobe is the pixel clock itself.
// R13: Load strobe output runs at the rate the mux mode needs.
// R14: 24-bit, 15-bit and 8-bit formats in every mux mode.
// R15: Load strobe output is pixel clock divided by 4, 2 or 1.
// R16: Lanes leave one per pixel clock, first lane first.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ppd_pixel_port
  import ppd_pkg::*;
#(
  parameter int FIFO_DEPTH = PPD_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pixel port pins
  input wire ppd_word_t pix_in,
  input wire logic load_strobe_in,
  // Register port
  input wire logic [PPD_AW-1:0] reg_addr_in,
  input wire logic [PPD_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [PPD_DW-1:0] reg_rdata_out,
  // Video and clocking outputs
  output ppd_video_t video_out,
  output logic separate_digital_sync_n_out,
  output logic load_strobe_out,
  output logic fifo_ready_out
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  ppd_ctrl_t ctrl;
  logic ovf;
  logic [PPD_DW-1:0] stat;
  logic ls_meta;
  logic ls_sync;
  logic ls_prev;
  ppd_word_t pix_meta;
  ppd_word_t pix_sync;
  logic cap;
  logic f_in_ready;
  ppd_word_t f_out_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [LW-1:0] level;
  logic [1:0] last;
  logic [1:0] div_cnt;
  ppd_state_t state;
  logic [1:0] idx;
  ppd_word_t hold;
  ppd_lane_t cur;
  logic sel;
  logic sync_act;
  logic shift_act;
  logic pop;

  // Register file
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl <= ppd_ctrl_t'(PPD_CTRL_RST);
    end else if (reg_wr_in && reg_addr_in == PPD_CTRL_ADDR) begin
      ctrl <= ppd_ctrl_t'(reg_wdata_in & PPD_CTRL_MASK);
    end
  end

  // Overrun while the FIFO is full; a new overrun beats the clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ovf <= 1'b0;
    end else if (cap && !f_in_ready) begin
      ovf <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == PPD_STAT_ADDR &&
                 reg_wdata_in[PPD_S_OVF]) begin
      ovf <= 1'b0;
    end
  end

  always_comb begin
    stat = '0;
    stat[PPD_S_OVF] = ovf;
    stat[LW-1:0] = level;
  end

  // Read data stands for the one cycle after the strobe only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        PPD_CTRL_ADDR: reg_rdata_out <= PPD_DW'(ctrl);
        PPD_STAT_ADDR: reg_rdata_out <= stat;
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // Pin synchronisers; the strobe and all lanes share the same delay
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ls_meta <= 1'b0;
      ls_sync <= 1'b0;
      ls_prev <= 1'b0;
    end else begin
      ls_meta <= load_strobe_in;
      ls_sync <= ls_meta;
      ls_prev <= ls_sync;
    end
  end

  always_ff @(posedge clk_in) begin
    pix_meta <= pix_in; // [R1] [R4]
    pix_sync <= pix_meta;
  end

  // Edge found on the pixel clock, so any strobe phase works; the
  // strobe rate must leave data stable for the synchroniser delay.
  // In 1:1 the strobe is the pixel clock, so every cycle is a load.
  always_comb begin
    cap = (ls_sync & ~ls_prev); // [R2] [R3] [R5]
    if (ctrl.mux == PPD_MUX_1) begin
      cap = 1'b1; // [R12]
    end
  end

  ppd_fifo #(
    .WIDTH($bits(ppd_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_data_in(pix_sync),
    .in_valid_in(cap),
    .in_ready_out(f_in_ready),
    .out_data_out(f_out_data),
    .out_valid_out(f_out_valid),
    .out_ready_in(f_out_ready),
    .level_out(level)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fifo_ready_out <= 1'b0;
    end else begin
      fifo_ready_out <= f_in_ready;
    end
  end

  // Mux mode sets both the strobe divisor and the lane count
  always_comb begin
    case (ctrl.mux)
      PPD_MUX_1: last = PPD_LAST_1;
      PPD_MUX_2: last = PPD_LAST_2;
      default: last = PPD_LAST_4;
    endcase
  end

  // Strobe divider; the >= compare recovers after a mode change
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_cnt <= '0;
    end else if (div_cnt >= last) begin
      div_cnt <= '0; // [R15]
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      load_strobe_out <= 1'b0;
    end else begin
      load_strobe_out <= (div_cnt >= last); // [R13] [R15]
    end
  end

  // Serializer
  assign f_out_ready = ctrl.run & (state == PPD_ST_IDLE || idx >= last);
  assign pop = f_out_ready & f_out_valid;
  assign shift_act = ctrl.run & (state == PPD_ST_SHIFT);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= PPD_ST_IDLE;
    end else if (f_out_ready) begin
      state <= f_out_valid ? PPD_ST_SHIFT : PPD_ST_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      idx <= '0;
    end else if (f_out_ready) begin
      idx <= '0; // [R16]
    end else if (ctrl.run) begin
      idx <= idx + 1'b1; // [R16]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hold <= '0;
    end else if (pop) begin
      hold <= f_out_data;
    end
  end

  // Select travels inside each lane, so it is judged per pixel
  assign cur = hold.lane[idx]; // [R11]
  assign sel = (cur.ps == ctrl.match); // [R9]
  assign sync_act = ctrl.green_sync & ~cur.sync_n; // [R7]

  function automatic ppd_rgb_t fmt_rgb(input ppd_rgb_t c,
                                       input logic [1:0] f);
    ppd_rgb_t o;
    o = c;
    case (f)
      PPD_FMT_15: o = {3'h0, c.r[7:3], 3'h0, c.g[7:3], 3'h0, c.b[7:3]};
      PPD_FMT_8: o = {c.r, c.r, c.r};
      default: o = c;
    endcase
    return o; // [R14]
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      video_out <= '0;
    end else if (!shift_act || !sel) begin
      video_out <= '0; // [R10]
    end else begin
      video_out.on <= 1'b1;
      video_out.blank <= ~cur.blank_n; // [R6]
      video_out.sync <= sync_act; // [R6] [R7]
      if (!cur.blank_n || sync_act) begin
        video_out.rgb <= '0; // [R6]
      end else begin
        video_out.rgb <= fmt_rgb(cur.rgb, ctrl.fmt); // [R14]
      end
    end
  end

  // Same register stage as video, so the latency matches exactly
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      separate_digital_sync_n_out <= 1'b1;
    end else if (shift_act && ctrl.sync_out_en) begin
      separate_digital_sync_n_out <= cur.sync_n; // [R8]
    end else begin
      separate_digital_sync_n_out <= 1'b1;
    end
  end

  // Checks
  property p_capture;
    @(posedge clk_in) disable iff (!rst_n_in)
    (ctrl.mux != PPD_MUX_1 && ls_sync && !ls_prev && f_in_ready && !pop)
      |=> level == $past(level) + 1'b1;
  endproperty
  a_capture: assert property (p_capture) // [R2]
    else $error("strobe edge did not store a word");

  property p_full_rate;
    @(posedge clk_in) disable iff (!rst_n_in)
    (ctrl.mux == PPD_MUX_1 && f_in_ready && !pop)
      |=> level == $past(level) + 1'b1;
  endproperty
  a_full_rate: assert property (p_full_rate) // [R12]
    else $error("1:1 mode missed a pixel");

  // The edge that takes a write still samples the old mode, so skip it
  property p_div4;
    @(posedge clk_in) disable iff (!rst_n_in || reg_wr_in)
    (!reg_wr_in && $rose(load_strobe_out) && ctrl.mux == PPD_MUX_4)
      |=> !load_strobe_out [*3] ##1 load_strobe_out;
  endproperty
  a_div4: assert property (p_div4) // [R15]
    else $error("strobe out not divided by 4");

  property p_div2;
    @(posedge clk_in) disable iff (!rst_n_in || reg_wr_in)
    (!reg_wr_in && load_strobe_out && ctrl.mux == PPD_MUX_2 &&
     $past(ctrl.mux) == PPD_MUX_2)
      |=> !load_strobe_out ##1 load_strobe_out;
  endproperty
  a_div2: assert property (p_div2) // [R13]
    else $error("strobe out not divided by 2");

  property p_unsel;
    @(posedge clk_in) disable iff (!rst_n_in)
    (shift_act && !sel) |=> (!video_out.on && video_out.rgb == '0);
  endproperty
  a_unsel: assert property (p_unsel) // [R10]
    else $error("unselected pixel drives current");

  property p_match;
    @(posedge clk_in) disable iff (!rst_n_in)
    (shift_act && cur.ps == ctrl.match) |=> video_out.on;
  endproperty
  a_match: assert property (p_match) // [R9]
    else $error("matching pixel not shown");

  property p_blank;
    @(posedge clk_in) disable iff (!rst_n_in)
    (shift_act && sel && !cur.blank_n)
      |=> (video_out.blank && video_out.rgb == '0);
  endproperty
  a_blank: assert property (p_blank) // [R6]
    else $error("blank not at blanking level");

  property p_no_gsync;
    @(posedge clk_in) disable iff (!rst_n_in)
    !ctrl.green_sync |=> !video_out.sync;
  endproperty
  a_no_gsync: assert property (p_no_gsync) // [R7]
    else $error("sync on green while disabled");

  property p_sync_out;
    @(posedge clk_in) disable iff (!rst_n_in)
    (shift_act && ctrl.sync_out_en)
      |=> separate_digital_sync_n_out == $past(cur.sync_n);
  endproperty
  a_sync_out: assert property (p_sync_out) // [R8]
    else $error("separate sync wrong or late");

  property p_lane_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (shift_act && idx < last) |=> idx == $past(idx) + 1'b1;
  endproperty
  a_lane_step: assert property (p_lane_step) // [R16]
    else $error("lane order broken");

  property p_ovf;
    @(posedge clk_in) disable iff (!rst_n_in)
    (cap && !f_in_ready) |=> ovf;
  endproperty
  a_ovf: assert property (p_ovf) // [R2]
    else $error("overrun not flagged");

  c_four: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl.mux == PPD_MUX_4 && shift_act && idx == PPD_LAST_4);
  c_gsync: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    video_out.sync && video_out.on);
  c_ovf: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(ovf));
  c_unsel: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    shift_act && !sel);
endmodule
`default_nettype wire

// ==== ppd_fb_model.sv ====
// Frame buffer stand-in that drives the pixel port pins
// Assumes the bench supplies words and counts take_out as a pop
`timescale 1ns/1ps
`default_nettype none
module ppd_fb_model
  import ppd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Word source
  input wire logic [1:0] mux_in,
  input wire ppd_word_t word_in,
  input wire logic valid_in,
  output logic take_out,
  // Pixel port pins
  output ppd_word_t pix_out,
  output logic load_strobe_out
);
  logic [1:0] phase;
  logic [1:0] last;
  logic [1:0] mid;
  logic sent;
  assign last = (mux_in == PPD_MUX_1) ? 2'h0 :
                (mux_in == PPD_MUX_2) ? 2'h1 : 2'h3;
  assign mid = (mux_in == PPD_MUX_2) ? 2'h1 : 2'h2;
  assign take_out = valid_in && (phase == 2'h0);
  // One word slot per strobe period
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || phase >= last) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // Between words the pins carry the idle word, never a stale pixel
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || phase == 2'h0) begin
      pix_out <= word_in;
      sent <= take_out && rst_n_in;
    end
  end
  // Strobe rises mid-slot so data is steady on both sides
  // In 1:1 the pixel clock itself loads, so the pin stays low
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || mux_in == PPD_MUX_1) begin
      load_strobe_out <= 1'b0;
    end else begin
      load_strobe_out <= sent && phase >= mid;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Testbench of the pixel port front end
// Assumes the design carries its own assertions
`timescale 1ns/1ps
`default_nettype none
module tb
  import ppd_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [PPD_AW-1:0] addr = '0;
  logic [PPD_DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [PPD_DW-1:0] rdata;
  ppd_video_t video;
  logic sync_n;
  logic ls_out;
  logic ready;
  logic strobe;
  logic take;
  logic [1:0] mux = PPD_MUX_4;
  ppd_word_t pix;
  ppd_word_t word;
  ppd_word_t idle = '0;
  ppd_word_t words [0:39];
  ppd_ctrl_t cfg;
  int idx = 0;
  int n_words = 0;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic reload = 1'b0;
  assign word = (idx < n_words) ? words[idx] : idle;

  ppd_fb_model fb (.clk_in(clk_in), .rst_n_in(rst_n_in), .mux_in(mux),
    .word_in(word), .valid_in(idx < n_words), .take_out(take),
    .pix_out(pix), .load_strobe_out(strobe));
  ppd_pixel_port #(.FIFO_DEPTH(PPD_FIFO_DEPTH)) dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .pix_in(pix), .load_strobe_in(strobe),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .video_out(video),
    .separate_digital_sync_n_out(sync_n), .load_strobe_out(ls_out),
    .fifo_ready_out(ready));

  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (reload) begin
      idx <= 0;
    end else if (take) begin
      idx <= idx + 1;
    end
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  function automatic ppd_video_t exp_vid(ppd_lane_t l, ppd_ctrl_t c);
    ppd_video_t v;
    v = '0;
    if (l.ps == c.match) begin
      v.on = 1'b1;
      v.blank = ~l.blank_n;
      v.sync = ~l.sync_n & c.green_sync;
      if (!(v.blank || v.sync)) begin
        case (c.fmt)
          PPD_FMT_15: v.rgb = {3'h0, l.rgb.r[7:3], 3'h0, l.rgb.g[7:3],
                               3'h0, l.rgb.b[7:3]};
          PPD_FMT_8: v.rgb = {3{l.rgb.r}};
          default: v.rgb = l.rgb;
        endcase
      end
    end
    return v;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    check({16'h0, rdata}, {16'h0, e});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check_stream(input int n, input int lanes);
    ppd_lane_t l;
    int w;
    w = 0;
    #1;
    while (video === '0 && w < 300) begin
      wait_cyc(1);
      w++;
    end
    for (int i = 0; i < n * lanes; i++) begin
      l = words[i / lanes].lane[i % lanes];
      check({4'h0, sync_n, video},
        {4'h0, cfg.sync_out_en ? l.sync_n : 1'b1, exp_vid(l, cfg)});
      wait_cyc(1);
    end
  endtask
  task automatic run_cfg(input logic [1:0] m, input logic [1:0] f,
                         input int n);
    int lanes;
    logic [31:0] c;
    lanes = (m == PPD_MUX_1) ? 1 : (m == PPD_MUX_2) ? 2 : 4;
    cfg = {7'h0, 1'b1, f, 2'($urandom), 2'($urandom), m};
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < PPD_LANES; k++) begin
        words[i].lane[k] = 28'($urandom);
        if ($urandom % 2) words[i].lane[k].ps = cfg.match;
        if ($urandom % 4) words[i].lane[k][3:2] = 2'b11;
        idle.lane[k] = {24'($urandom), 2'b11, ~cfg.match};
      end
    end
    // Leading lit pixel lets the stream be found after any idle gap
    words[0].lane[0] = {24'hf8f8f8 | 24'($urandom), 2'b11, cfg.match};
    mux <= m;
    reg_write(PPD_CTRL_ADDR, cfg);
    wait_cyc(8);
    c = '0;
    repeat (12) begin
      wait_cyc(1);
      c += ls_out;
    end
    check(c, 12 / lanes);
    if (lanes > 1) begin
      cfg.run = 1'b0;
      reg_write(PPD_CTRL_ADDR, cfg);
    end
    reload <= 1'b1;
    @(posedge clk_in);
    reload <= 1'b0;
    n_words <= n;
    if (lanes > 1) begin
      wait_cyc(4 * n + 10);
      if (n > PPD_FIFO_DEPTH) begin
        check({31'h0, ready}, 32'h0);
        reg_read(PPD_STAT_ADDR, 16'h0120);
        reg_write(PPD_STAT_ADDR, 16'h0100);
        reg_read(PPD_STAT_ADDR, 16'h0020);
        n = PPD_FIFO_DEPTH;
      end
      cfg.run = 1'b1;
      reg_write(PPD_CTRL_ADDR, cfg);
    end
    check_stream(n, lanes);
    reg_read(PPD_STAT_ADDR, (lanes == 1) ? 16'h0001 : 16'h0000);
    check({31'h0, ready}, 32'h1);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(50));
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    reg_read(PPD_CTRL_ADDR, PPD_CTRL_RST);
    reg_read(PPD_STAT_ADDR, 16'h0000);
    reg_read(4'h8, 16'h0000);
    reg_write(4'hc, 16'hffff);
    reg_read(PPD_CTRL_ADDR, PPD_CTRL_RST);
    reg_write(PPD_CTRL_ADDR, 16'hfefe);
    reg_read(PPD_CTRL_ADDR, 16'hfefe & PPD_CTRL_MASK);
    $display("test registers done");
    run_cfg(PPD_MUX_4, PPD_FMT_24, 34);
    $display("test overrun done");
    for (int m = 0; m < 3; m++) begin
      for (int f = 0; f < 4; f++) begin
        run_cfg(2'(m), 2'(f), 6);
        $display("test mux %0d fmt %0d done", m, f);
      end
    end
    run_cfg(2'h3, PPD_FMT_24, 6);
    $display("test spare mux done");
    finish_test();
  end
endmodule
`default_nettype wire
